// File: pll_cfg_defines.vh
// Constants for the clock conditioning configuration decode block
`ifndef PLL_CFG_DEFINES_VH
`define PLL_CFG_DEFINES_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define REG_DIV_CFG 12'h000
`define REG_OUT_DIV 12'h004
`define REG_OUT_SEL 12'h008
`define REG_STATUS 12'h00c

// ************************************************************
// Field positions and reset values
// ************************************************************
`define FLD_IN_DIV_LSB 0
`define FLD_FB_DIV_LSB 8
`define FLD_EXT_FB_BIT 16
`define FLD_OUT_DIV_STRIDE 8
`define FLD_OUT_SEL_STRIDE 4
`define FLD_DELAY_LSB 12
`define RST_DIV_CFG 32'h00000000
`define RST_OUT_DIV 32'h00000000
`define RST_OUT_SEL 32'h00000000

// ************************************************************
// Source select codes
// ************************************************************
`define SEL_BYPASS 3'h0
`define SEL_RSVD_1 3'h1
`define SEL_DELAY_LINE 3'h2
`define SEL_RSVD_3 3'h3
`define SEL_PH_0 3'h4
`define SEL_PH_270 3'h5
`define SEL_PH_180 3'h6
`define SEL_PH_90 3'h7

// ************************************************************
// Block location codes
// ************************************************************
`define LOC_EAST_WEST 1'b0
`define LOC_CORNER 1'b1

`endif

// File: pulse_divider.v
// Programmable pulse divider: one output pulse per (code + 1) input pulses
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
  parameter W = 7
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Divisor code and pulses
  input wire [W-1:0] code,
  input wire pulse_in,
  output reg pulse_out
);

reg [W-1:0] count_r;

// Count input pulses; each pulse is compared with the current code, so a code change applies at once
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    count_r <= {W{1'b0}};
    pulse_out <= 1'b0;
  end
  else
  begin
    pulse_out <= 1'b0;
    if (pulse_in)
    begin
      if (count_r >= code)
      begin
        count_r <= {W{1'b0}};
        pulse_out <= 1'b1;
      end
      else
      begin
        count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
end

endmodule // pulse_divider
`default_nettype wire

// File: pll_clock_config_decode.v
// Clock conditioning configuration decode with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_defines.vh"
module pll_clock_config_decode #(
  parameter LOCATION = `LOC_EAST_WEST,
  parameter SMALL_DEVICE = 0
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Clock inputs, sampled as synchronous levels
  input wire reference_clock_in,
  input wire external_feedback_clock,
  // Decoded divisors
  output reg [7:0] input_divisor,
  output reg [7:0] feedback_divisor,
  output reg [17:0] out_divisors,
  // Output clock pulses, one bit per output a, b, c
  output reg [2:0] out_clock_pulse,
  // Global line drive enables, one per line
  output reg [2:0] global_line_enable,
  // Phase detector view
  output reg phase_ref_leads
);

// ************************************************************
// Reset release
// ************************************************************
reg rst_meta_r;
reg rst_n_r;

// Two-stage release keeps reset deassertion synchronous
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    rst_meta_r <= 1'b0;
    rst_n_r <= 1'b0;
  end
  else
  begin
    rst_meta_r <= 1'b1;
    rst_n_r <= rst_meta_r;
  end
end

// ************************************************************
// Registers
// ************************************************************
reg [31:0] div_cfg_r;
reg [31:0] out_div_r;
reg [31:0] out_sel_r;
wire wr_en;
wire [6:0] input_divider_code;
wire [6:0] feedback_divider_code;
wire ext_fb_en;
wire [4:0] out_a_divider_code;
wire [4:0] out_b_divider_code;
wire [4:0] out_c_divider_code;
wire [2:0] out_a_source_select;
wire [2:0] out_b_source_select;
wire [2:0] out_c_source_select;
wire [2:0] delay_steps;

assign wr_en = psel & penable & pwrite;

// Writes take effect in the access cycle; zero wait states
always @(posedge mclk or negedge rst_n_r)
begin
  if (!rst_n_r)
  begin
    div_cfg_r <= `RST_DIV_CFG;
    out_div_r <= `RST_OUT_DIV;
    out_sel_r <= `RST_OUT_SEL;
  end
  else if (wr_en)
  begin
    case (paddr)
      `REG_DIV_CFG: div_cfg_r <= pwdata & 32'h00017f7f;
      `REG_OUT_DIV: out_div_r <= pwdata & 32'h001f1f1f;
      `REG_OUT_SEL: out_sel_r <= pwdata & 32'h00007777;
      default: div_cfg_r <= div_cfg_r;
    endcase
  end
end

assign input_divider_code = div_cfg_r[`FLD_IN_DIV_LSB +: 7];
assign feedback_divider_code = div_cfg_r[`FLD_FB_DIV_LSB +: 7];
assign ext_fb_en = div_cfg_r[`FLD_EXT_FB_BIT];
assign out_a_divider_code = out_div_r[0 +: 5];
assign out_b_divider_code = out_div_r[`FLD_OUT_DIV_STRIDE +: 5];
assign out_c_divider_code = out_div_r[2*`FLD_OUT_DIV_STRIDE +: 5];
assign out_a_source_select = out_sel_r[0 +: 3];
assign out_b_source_select = out_sel_r[`FLD_OUT_SEL_STRIDE +: 3];
assign out_c_source_select = out_sel_r[2*`FLD_OUT_SEL_STRIDE +: 3];
assign delay_steps = out_sel_r[`FLD_DELAY_LSB +: 3];

// Reserved codes carry no clock
function is_reserved;
  input [2:0] sel;
  begin
    is_reserved = (sel == `SEL_RSVD_1) || (sel == `SEL_RSVD_3);
  end
endfunction

// Status word and read mux; unmapped reads give zero with an error
wire [31:0] status_word;
reg [31:0] rdata;
reg addr_ok;

assign status_word = {11'h000, global_line_enable,
  (is_reserved(out_a_source_select) | is_reserved(out_b_source_select) | is_reserved(out_c_source_select)),
  phase_ref_leads, feedback_divisor, input_divisor};

always @*
begin
  rdata = 32'h00000000;
  addr_ok = 1'b1;
  case (paddr)
    `REG_DIV_CFG: rdata = div_cfg_r;
    `REG_OUT_DIV: rdata = out_div_r;
    `REG_OUT_SEL: rdata = out_sel_r;
    `REG_STATUS: rdata = status_word;
    default: addr_ok = 1'b0;
  endcase
end

assign prdata = (psel & penable & ~pwrite) ? rdata : 32'h00000000;
assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_ok;

// ************************************************************
// Divisor decode
// ************************************************************
// Registered so the divisor outputs are clean flip-flop values
always @(posedge mclk or negedge rst_n_r)
begin
  if (!rst_n_r)
  begin
    input_divisor <= 8'h01;
    feedback_divisor <= 8'h01;
    out_divisors <= 18'h00000;
  end
  else
  begin
    input_divisor <= {1'b0, input_divider_code} + 8'h01;
    feedback_divisor <= {1'b0, feedback_divider_code} + 8'h01;
    out_divisors <= {{1'b0, out_c_divider_code} + 6'h01,
      {1'b0, out_b_divider_code} + 6'h01,
      {1'b0, out_a_divider_code} + 6'h01};
  end
end

// ************************************************************
// Clock event model
// ************************************************************
reg ref_d_r;
reg external_feedback_clock_d_r;
reg [1:0] vco_phase_r;
reg [7:0] delay_line_r;
wire ref_edge;
wire external_feedback_clock_edge;
wire ref_div_pulse;
wire int_fb_pulse;
wire fb_pulse;
wire delay_out;

// Edge detect on the sampled pins; the oscillator is modelled as mclk in four phases
always @(posedge mclk or negedge rst_n_r)
begin
  if (!rst_n_r)
  begin
    ref_d_r <= 1'b0;
    external_feedback_clock_d_r <= 1'b0;
    vco_phase_r <= 2'h0;
    delay_line_r <= 8'h00;
  end
  else
  begin
    ref_d_r <= reference_clock_in;
    external_feedback_clock_d_r <= external_feedback_clock;
    vco_phase_r <= vco_phase_r + 2'h1;
    delay_line_r <= {delay_line_r[6:0], fb_pulse};
  end
end

assign ref_edge = reference_clock_in & ~ref_d_r;
assign external_feedback_clock_edge = external_feedback_clock & ~external_feedback_clock_d_r;

pulse_divider #(.W(7)) u_in_div (
  .mclk(mclk),
  .rst_n(rst_n_r),
  .code(input_divider_code),
  .pulse_in(ref_edge),
  .pulse_out(ref_div_pulse)
);

pulse_divider #(.W(7)) u_fb_div (
  .mclk(mclk),
  .rst_n(rst_n_r),
  .code(feedback_divider_code),
  .pulse_in(vco_phase_r == 2'h0),
  .pulse_out(int_fb_pulse)
);

// Feedback source for the phase detector
assign fb_pulse = ext_fb_en ? external_feedback_clock_edge : int_fb_pulse;
assign delay_out = delay_line_r[delay_steps];

// Phase detector: remembers which input arrived last
always @(posedge mclk or negedge rst_n_r)
begin
  if (!rst_n_r)
    phase_ref_leads <= 1'b0;
  else if (ref_div_pulse & ~fb_pulse)
    phase_ref_leads <= 1'b1;
  else if (fb_pulse & ~ref_div_pulse)
    phase_ref_leads <= 1'b0;
end

// ************************************************************
// Output muxes and dividers
// ************************************************************
// Source for one output; reserved codes yield nothing
function mux_source;
  input [2:0] sel;
  input bypass_in;
  input dly_in;
  input [1:0] phase;
  begin
    case (sel)
      `SEL_BYPASS: mux_source = bypass_in;
      `SEL_DELAY_LINE: mux_source = dly_in;
      `SEL_PH_0: mux_source = (phase == 2'h0);
      `SEL_PH_270: mux_source = (phase == 2'h3);
      `SEL_PH_180: mux_source = (phase == 2'h2);
      `SEL_PH_90: mux_source = (phase == 2'h1);
      default: mux_source = 1'b0;
    endcase
  end
endfunction

wire [8:0] sel_all;
wire [14:0] div_all;
wire [2:0] div_pulse;

assign sel_all = {out_c_source_select, out_b_source_select, out_a_source_select};
assign div_all = {out_c_divider_code, out_b_divider_code, out_a_divider_code};

genvar gi;
generate
  for (gi = 0; gi < 3; gi = gi + 1)
  begin : g_out
    wire src;
    assign src = mux_source(sel_all[3*gi +: 3], ref_edge, delay_out, vco_phase_r);
    pulse_divider #(.W(5)) u_out_div (
      .mclk(mclk),
      .rst_n(rst_n_r),
      .code(div_all[5*gi +: 5]),
      .pulse_in(src),
      .pulse_out(div_pulse[gi])
    );
  end
endgenerate

// Bypass skips the output divider so the input goes straight through
always @(posedge mclk or negedge rst_n_r)
begin
  if (!rst_n_r)
    out_clock_pulse <= 3'h0;
  else
  begin
    out_clock_pulse[0] <= (out_a_source_select == `SEL_BYPASS) ? ref_edge : div_pulse[0];
    out_clock_pulse[1] <= (out_b_source_select == `SEL_BYPASS) ? ref_edge : div_pulse[1];
    out_clock_pulse[2] <= (out_c_source_select == `SEL_BYPASS) ? ref_edge : div_pulse[2];
  end
end

// ************************************************************
// Global line reach
// ************************************************************
// A line is driven while its output has a real source; corners lose reach on small parts
always @(posedge mclk or negedge rst_n_r)
begin
  if (!rst_n_r)
    global_line_enable <= 3'h0;
  else if (LOCATION == `LOC_CORNER && SMALL_DEVICE != 0)
    global_line_enable <= 3'h0;
  else
    global_line_enable <= {~is_reserved(out_c_source_select),
      ~is_reserved(out_b_source_select),
      ~is_reserved(out_a_source_select)};
end

endmodule // pll_clock_config_decode
`default_nettype wire

// File: pll_cfg_props.sv
// Port assertions for the clock configuration decode block
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_props (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Decode outputs
  input wire [7:0] input_divisor,
  input wire [7:0] feedback_divisor,
  input wire [17:0] out_divisors,
  input wire [2:0] global_line_enable,
  input wire phase_ref_leads
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Status read and write access phases
  wire st = psel && penable && !pwrite && paddr == 12'h00c;
  wire wa = psel && penable && pwrite;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access phase");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access phase");
  property p_idle; !(psel && penable) |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero when idle");
  property p_in; st |-> prdata[7:0] == input_divisor && input_divisor != 8'h00; endproperty
  a_in: assert property (p_in) else $error("input divisor status mismatch");
  property p_fb; st |-> prdata[15:8] == feedback_divisor && feedback_divisor != 8'h00; endproperty
  a_fb: assert property (p_fb) else $error("feedback divisor status mismatch");
  property p_out; out_divisors[5:0] <= 6'h20 && out_divisors[11:6] <= 6'h20 && out_divisors[17:12] <= 6'h20; endproperty
  a_out: assert property (p_out) else $error("output divisor above 32");
  property p_gl; st |-> prdata[20:18] == global_line_enable; endproperty
  a_gl: assert property (p_gl) else $error("line enable status mismatch");
  property p_rsv; st |-> prdata[17] == !(&global_line_enable); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag mismatch");
  property p_ph; st |-> prdata[16] == phase_ref_leads; endproperty
  a_ph: assert property (p_ph) else $error("phase flag status mismatch");
  // The input divisor only moves shortly after a register write
  property p_chg; $changed(input_divisor) |-> $past(wa, 1) || $past(wa, 2) || $past(wa, 3); endproperty
  a_chg: assert property (p_chg) else $error("input divisor moved without a write");
  // Decoded divisors follow the written code two edges after the access
  property p_in_dec;
    wa && paddr == 12'h000 |-> ##2 input_divisor == {1'b0, $past(pwdata[6:0], 2)} + 8'h01;
  endproperty
  a_in_dec: assert property (p_in_dec) else $error("input divisor not code plus one");
  property p_fb_dec;
    wa && paddr == 12'h000 |-> ##2 feedback_divisor == {1'b0, $past(pwdata[14:8], 2)} + 8'h01;
  endproperty
  a_fb_dec: assert property (p_fb_dec) else $error("feedback divisor not code plus one");
  property p_out_dec;
    wa && paddr == 12'h004 |-> ##2 out_divisors == {{1'b0, $past(pwdata[20:16], 2)} + 6'h01,
      {1'b0, $past(pwdata[12:8], 2)} + 6'h01, {1'b0, $past(pwdata[4:0], 2)} + 6'h01};
  endproperty
  a_out_dec: assert property (p_out_dec) else $error("output divisor not code plus one");
  c_st: cover property (st);
  c_err: cover property (pslverr);
  c_chg: cover property ($changed(feedback_divisor));
  c_ph: cover property ($fell(phase_ref_leads));
endmodule // pll_cfg_props
bind pll_clock_config_decode pll_cfg_props pll_cfg_props_i (.mclk(mclk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr),
  .input_divisor(input_divisor), .feedback_divisor(feedback_divisor), .out_divisors(out_divisors),
  .global_line_enable(global_line_enable), .phase_ref_leads(phase_ref_leads));
`default_nettype wire

// File: fabric_clk_model.sv
// Far-side model driving the reference and external feedback clock pins
`timescale 1ns/1ps
`default_nettype none
module fabric_clk_model #(
  parameter REF_HALF = 3,
  parameter EXT_HALF = 5
) (
  // Clock
  input wire logic mclk,
  // Clock pins toward the block
  output logic reference_clock_in,
  output logic external_feedback_clock
);
  // ************************************************************
  // Pin generators
  // ************************************************************
  int rc = 0;
  int ec = 0;
  // Free-running, changed just after mclk edges so sampling never races
  always @(posedge mclk)
  begin
    rc <= (rc == 2 * REF_HALF - 1) ? 0 : rc + 1;
    ec <= (ec == 2 * EXT_HALF - 1) ? 0 : ec + 1;
  end
  assign reference_clock_in = (rc >= REF_HALF);
  // Straight from a dedicated pin, no fabric logic in the path
  assign external_feedback_clock = (ec >= EXT_HALF);
endmodule // fabric_clk_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the clock configuration decode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ************************************************************
  // Signals, tasks and sequence
  // ************************************************************
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, ref_clk, ext_clk, phase_ref_leads, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] input_divisor, feedback_divisor;
  logic [17:0] out_divisors;
  logic [2:0] out_clock_pulse, global_line_enable;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, t1;
  pll_clock_config_decode pll_clock_config_decode_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock_in(ref_clk), .external_feedback_clock(ext_clk), .input_divisor(input_divisor),
    .feedback_divisor(feedback_divisor), .out_divisors(out_divisors), .out_clock_pulse(out_clock_pulse),
    .global_line_enable(global_line_enable), .phase_ref_leads(phase_ref_leads));
  fabric_clk_model fabric_clk_model_i (.mclk(mclk), .reference_clock_in(ref_clk),
    .external_feedback_clock(ext_clk));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cycle count, also the hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end
  task summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  // Cycle of the next pulse on one output, bounded
  task pw(input int b, output int t);
    int n;
    n = 0;
    @(posedge mclk);
    while (out_clock_pulse[b] !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      n++;
    end
    t = cyc;
  endtask
  // Counts cycles with the phase flag low and high over a short window
  task flag_seen(output int lo, output int hi);
    lo = 0;
    hi = 0;
    repeat (40)
    begin
      @(posedge mclk);
      if (phase_ref_leads === 1'b0)
        lo++;
      if (phase_ref_leads === 1'b1)
        hi++;
    end
  endtask
  task per(input string n, input int b, input int e);
    pw(b, t0);
    pw(b, t1);
    chk(n, e, t1 - t0);
  endtask
  initial
  begin
    {rstn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk("out_sel", 12'h008, 32'hffffffff, 32'h0);
    rchk("status", 12'h00c, 32'hfffeffff, 32'h001c0101);
    wr(12'h000, 32'hffffffff);
    rchk("div_cfg", 12'h000, 32'hffffffff, 32'h00017f7f);
    rchk("div_max", 12'h00c, 32'h0000ffff, 32'h00008080);
    wr(12'h004, 32'hffffffff);
    repeat (3) @(posedge mclk);
    chk("out_max", {6'h20, 6'h20, 6'h20}, out_divisors);
    wr(12'h010, 32'h1);
    chk("unmapped", 1'b1, er);
    wr(12'h00c, 32'hffffffff);
    chk("status_wr_err", 1'b0, er);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h0);
    repeat (3) @(posedge mclk);
    chk("out_min", {6'h01, 6'h01, 6'h01}, out_divisors);
    rchk("div_min", 12'h00c, 32'h0000ffff, 32'h00000101);
    wr(12'h008, 32'h0654);
    per("ph0", 0, 4);
    pw(0, t0);
    pw(1, t1);
    chk("ph270", 3, (t1 - t0) % 4);
    pw(2, t1);
    chk("ph180", 2, (t1 - t0) % 4);
    wr(12'h008, 32'h0754);
    pw(0, t0);
    pw(2, t1);
    chk("ph90", 1, (t1 - t0) % 4);
    wr(12'h004, 32'h2);
    per("odiv", 0, 12);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h0200);
    wr(12'h008, 32'h0442);
    per("dline", 0, 12);
    wr(12'h000, 32'h00010000);
    per("external_feedback_clock", 0, 10);
    wr(12'h008, 32'h0440);
    per("bypass", 0, 6);
    wr(12'h008, 32'h0431);
    rchk("rsvd", 12'h00c, 32'h001e0000, 32'h00120000);
    t0 = 0;
    repeat (40)
    begin
      @(posedge mclk);
      t0 += (out_clock_pulse[1:0] !== 2'b00);
    end
    chk("rsvd_quiet", 0, t0);
    wr(12'h000, 32'h00007f00);
    flag_seen(t0, t1);
    chk("ref_leads", 1, t1 > 0);
    wr(12'h000, 32'h00017f00);
    flag_seen(t0, t1);
    chk("fb_leads", 1, t0 > 0);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
